/* inc/fpc_pkg.sv */
// ------------------------------------------------------------
// Flash program controller constants
// ------------------------------------------------------------
package fpc_pkg;

  // Array geometry: 32 KB main array, 256-byte rows, 64-byte pages
  localparam int ADDR_W      = 15;
  localparam int WORD_AW     = 13;
  localparam int NUM_WORDS   = 8192;
  localparam int PAGE_WORDS  = 16;
  localparam int PAGE_IW     = 4;
  localparam int ROW_IW      = 6;
  localparam int ROW_W       = 7;
  localparam int ROW_LSB     = 8;
  localparam int PAGE_LSB    = 6;
  localparam int WORD_LSB    = 2;
  localparam int HALF_BIT    = 1;
  localparam int REGION_W    = 4;
  localparam int NUM_REGIONS = 16;
  localparam logic [ROW_W:0] NUM_ROWS = 8'h80;

  // Register byte offsets
  localparam logic [7:0] REG_CMD     = 8'h00;
  localparam logic [7:0] REG_CFG     = 8'h04;
  localparam logic [7:0] REG_INTERRUPT_FLAG_REG = 8'h14;
  localparam logic [7:0] REG_STATUS  = 8'h18;
  localparam logic [7:0] REG_ADDR    = 8'h1c;
  localparam logic [7:0] REG_LOCK    = 8'h20;

  // Command register fields
  localparam int CMD_LSB = 0;
  localparam int CMD_MSB = 6;
  localparam int KEY_LSB = 8;
  localparam int KEY_MSB = 15;
  localparam logic [7:0] CMD_KEY = 8'h3c;
  localparam logic [6:0] CMD_WRITE_PAGE = 7'h01;
  localparam logic [6:0] CMD_ERASE_ROW  = 7'h02;
  localparam logic [6:0] CMD_LOCK       = 7'h03;
  localparam logic [6:0] CMD_UNLOCK     = 7'h04;
  localparam logic [6:0] CMD_PBUF_CLR   = 7'h05;

  // Configuration register fields
  localparam int CFG_RWS_LSB  = 1;
  localparam int CFG_RWS_MSB  = 4;
  localparam int CFG_MANUAL_WRITE_SEL_BIT = 7;
  localparam int CFG_SPR_LSB  = 8;
  localparam int CFG_SPR_MSB  = 9;
  localparam logic [1:0] SPR_OFF = 2'h3;

  // Flag and status bits
  localparam int INTF_READY_BIT = 0;
  localparam int INTF_ERROR_BIT = 1;
  localparam int ST_LOWPWR_BIT  = 0;
  localparam int ST_LOAD_BIT    = 1;
  localparam int ST_PROGE_BIT   = 2;
  localparam int ST_ERASE_PROTECT_ERROR_BIT   = 3;
  localparam int ADDR_AUX_BIT   = 31;

  // User configuration word 0 in the auxiliary page
  localparam int AUX_LOCK_LSB = 0;
  localparam int AUX_LOCK_MSB = 15;
  localparam int AUX_BOOT_LSB = 16;
  localparam int AUX_BOOT_MSB = 18;
  localparam int AUX_EE_LSB   = 20;
  localparam int AUX_EE_MSB   = 22;
  localparam logic [2:0] FUSE_NONE = 3'h7;

  // Memory bus access sizes
  localparam logic [1:0] SIZE_8  = 2'h0;
  localparam logic [1:0] SIZE_32 = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int PWRUP_TIME_NS = 2000;
  localparam int PROG_TIME_NS  = 2500;
  localparam int ERASE_TIME_NS = 6000;
  localparam int LOCK_TIME_NS  = 100;
  localparam int TIMER_W       = 9;
  localparam int PWRUP_CYC =
    (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYC =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYC =
    (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum {
    SEQ_POWERUP, SEQ_IDLE, SEQ_PROG, SEQ_ERASE, SEQ_WAIT
  } fpc_seq_t;

  typedef enum {MS_IDLE, MS_WAIT, MS_DONE} fpc_mem_t;

endpackage

/* rtl/fpc_flash_program_controller.sv */
// Overview of operation
// - Keeps running in sleep; ready can wake system
// - Sleep puts array in low power per setting
// - Security active refuses external array access
// - Guard blocks writes except flag and status
// - Power-up sequence stalls bus, then usable
// - Rows of four pages; erase row, program page
// - Boot section guarded by lock and fuse
// - Emulated EEPROM rows writable whatever the lock bits, except rows also inside the boot fuse section
// - Sixteen regions, lock bits, start unlocked
// - Lock/unlock target region, readable lock register
// - Default locks from auxiliary page after reset
// - Stall flash accesses during program or erase
// - Command needs key; ready low until done
// - Commands while not ready are ignored
// - Reads answer after configured wait cycles
// - Main array reads stall during operations
// - One-page buffer; byte writes raise error
// - Buffer writes capture target location
// - Status shows page buffer loaded
// - Auto mode programs page on last location
// - Buffer set to ones after write, clear
// - Row erase sets whole row to ones
// - Erase of locked region sets lock error
`timescale 1ns/1ps
module fpc_flash_program_controller
  import fpc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              por_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              mem_req_i,
  input  wire logic              mem_we_i,
  input  wire logic              mem_aux_i,
  input  wire logic              mem_ext_i,
  input  wire logic [1:0]        mem_size_i,
  input  wire logic [ADDR_W-1:0] mem_addr_i,
  input  wire logic [31:0]       mem_wdata_i,
  output logic      [31:0]       mem_rdata_o,
  output logic                   mem_ack_o,
  output logic                   mem_err_o,
  input  wire logic              guard_wp_i,
  input  wire logic              sleep_i,
  input  wire logic              security_i,
  output logic                   ready_o,
  output logic                   flash_lowpwr_o,
  output logic                   wake_o
);

  // ----------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------
  logic [31:0]         main_mem [NUM_WORDS];
  logic [31:0]         aux_mem  [PAGE_WORDS];
  logic [31:0]         pbuf     [PAGE_WORDS];
  fpc_seq_t            seq_q, seq_d;
  fpc_mem_t            mst_q;
  logic [TIMER_W-1:0]  timer_q, timer_d;
  logic [ROW_IW-1:0]   idx_q, idx_d;
  logic [3:0]          wcnt_q;
  logic [ADDR_W-1:0]   addr_q;
  logic                addr_aux_q;
  logic [NUM_REGIONS-1:0] lock_q;
  logic [2:0]          boot_fuse_q, ee_fuse_q;
  logic [3:0]          rws_q;
  logic                manual_write_sel_q;
  logic [1:0]          spr_q;
  logic                loaded_q, lock_err_q, prog_err_q, err_flag_q;
  logic                ack_q, ready_q, ready_prev_q;
  logic                ev_lock_err, ev_prog_err, buf_fill;

  // ----------------------------------------------------------
  // Protection decode
  // ----------------------------------------------------------
  function automatic logic [ROW_W:0] fuse_rows(input logic [2:0] code,
                                               input logic       boot);
    logic [ROW_W:0] base;
    base = boot ? 8'h02 : 8'h01;
    if (code == FUSE_NONE)
      fuse_rows = 8'h00;
    else
      fuse_rows = base << (3'h6 - code);
  endfunction

  function automatic logic row_writable(input logic [ROW_W-1:0] row);
    logic [ROW_W:0] r;
    r = {1'b0, row};
    if (r < fuse_rows(boot_fuse_q, 1'b1))
      row_writable = 1'b0;
    else if (r >= NUM_ROWS - fuse_rows(ee_fuse_q, 1'b0))
      row_writable = 1'b1;
    else
      row_writable = lock_q[row[ROW_W-1 -: REGION_W]];
  endfunction

  // ----------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------
  logic       wb_req, wb_wr, reg_wr_ok, cmd_issue;
  logic [6:0] cmd_code;
  logic [ROW_W-1:0] tgt_row;
  logic [PAGE_IW-1:0] widx;
  logic       last_loc, mem_take_wr, seq_idle;

  assign wb_req    = wb_cyc_i & wb_stb_i;
  assign wb_wr     = wb_req & wb_we_i & ack_q;
  assign reg_wr_ok = wb_wr & ~guard_wp_i;
  assign seq_idle  = (seq_q == SEQ_IDLE);
  assign cmd_code  = wb_dat_i[CMD_MSB:CMD_LSB];
  assign cmd_issue = reg_wr_ok & (wb_adr_i == REG_CMD) & wb_sel_i[0] &
                     wb_sel_i[1] & seq_idle &
                     (wb_dat_i[KEY_MSB:KEY_LSB] == CMD_KEY);
  assign tgt_row   = addr_q[ADDR_W-1:ROW_LSB];
  assign widx      = mem_addr_i[PAGE_LSB-1:WORD_LSB];
  assign last_loc  = (widx == PAGE_IW'(PAGE_WORDS - 1)) &&
                     (mem_size_i == SIZE_32 || mem_addr_i[HALF_BIT]);
  assign mem_take_wr = (mst_q == MS_IDLE) & mem_req_i & mem_we_i &
                       ~mem_ack_o & ~mem_err_o & seq_idle &
                       (mem_size_i != SIZE_8) &
                       ~(security_i & mem_ext_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req & ~ack_q;
      if (wb_req & ~ack_q) begin
        case (wb_adr_i)
          REG_CFG:     wb_dat_o <= {22'h0, spr_q, manual_write_sel_q, 2'h0,
                                    rws_q, 1'b0};
          REG_INTERRUPT_FLAG_REG: wb_dat_o <= {30'h0, err_flag_q, seq_idle};
          REG_STATUS:  wb_dat_o <= {28'h0, lock_err_q, prog_err_q,
                                    loaded_q, flash_lowpwr_o};
          REG_ADDR:    wb_dat_o <= {addr_aux_q, 16'h0, addr_q};
          REG_LOCK:    wb_dat_o <= {16'h0, lock_q};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rws_q  <= 4'h0;
      manual_write_sel_q <= 1'b0;
      spr_q  <= 2'h0;
    end else if (reg_wr_ok && wb_adr_i == REG_CFG) begin
      if (wb_sel_i[0]) begin
        rws_q  <= wb_dat_i[CFG_RWS_MSB:CFG_RWS_LSB];
        manual_write_sel_q <= wb_dat_i[CFG_MANUAL_WRITE_SEL_BIT];
      end
      if (wb_sel_i[1])
        spr_q <= wb_dat_i[CFG_SPR_MSB:CFG_SPR_LSB];
    end
  end

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  always_comb begin
    seq_d       = seq_q;
    timer_d     = timer_q;
    idx_d       = idx_q;
    ev_lock_err = 1'b0;
    ev_prog_err = 1'b0;
    buf_fill    = 1'b0;
    case (seq_q)
      SEQ_POWERUP: begin
        timer_d = timer_q - 1'b1;
        if (timer_q == '0)
          seq_d = SEQ_IDLE;
      end
      SEQ_IDLE: begin
        idx_d = '0;
        if (mem_take_wr && last_loc && !manual_write_sel_q) begin
          if (mem_aux_i || row_writable(mem_addr_i[ADDR_W-1:ROW_LSB]))
            seq_d = SEQ_PROG;
          else
            ev_lock_err = 1'b1;
        end else if (cmd_issue) begin
          case (cmd_code)
            CMD_WRITE_PAGE: begin
              if (addr_aux_q || row_writable(tgt_row))
                seq_d = SEQ_PROG;
              else
                ev_lock_err = 1'b1;
            end
            CMD_ERASE_ROW: begin
              if (addr_aux_q)
                ev_prog_err = 1'b1;
              else if (row_writable(tgt_row))
                seq_d = SEQ_ERASE;
              else
                ev_lock_err = 1'b1;
            end
            CMD_LOCK, CMD_UNLOCK: begin
              seq_d   = SEQ_WAIT;
              timer_d = TIMER_W'(LOCK_CYC - 1);
            end
            CMD_PBUF_CLR: begin
              buf_fill = 1'b1;
              seq_d    = SEQ_WAIT;
              timer_d  = TIMER_W'(LOCK_CYC - 1);
            end
            default: ev_prog_err = 1'b1;
          endcase
        end
      end
      SEQ_PROG: begin
        idx_d = idx_q + 1'b1;
        if (idx_q == ROW_IW'(PAGE_WORDS - 1)) begin
          buf_fill = 1'b1;
          seq_d    = SEQ_WAIT;
          timer_d  = TIMER_W'(PROG_CYC - 1);
        end
      end
      SEQ_ERASE: begin
        idx_d = idx_q + 1'b1;
        if (idx_q == '1) begin
          seq_d   = SEQ_WAIT;
          timer_d = TIMER_W'(ERASE_CYC - 1);
        end
      end
      SEQ_WAIT: begin
        timer_d = timer_q - 1'b1;
        if (timer_q == '0)
          seq_d = SEQ_IDLE;
      end
      default: seq_d = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q   <= SEQ_POWERUP;
      timer_q <= TIMER_W'(PWRUP_CYC - 1);
      idx_q   <= '0;
      ready_q <= 1'b0;
    end else begin
      seq_q   <= seq_d;
      timer_q <= timer_d;
      idx_q   <= idx_d;
      ready_q <= (seq_d == SEQ_IDLE);
    end
  end
  assign ready_o = ready_q;

  // ----------------------------------------------------------
  // Array and auxiliary page
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (seq_q == SEQ_PROG && !addr_aux_q)
      main_mem[{addr_q[ADDR_W-1:PAGE_LSB], idx_q[PAGE_IW-1:0]}] <=
        main_mem[{addr_q[ADDR_W-1:PAGE_LSB], idx_q[PAGE_IW-1:0]}] &
        pbuf[idx_q[PAGE_IW-1:0]];
    else if (seq_q == SEQ_ERASE)
      main_mem[{tgt_row, idx_q}] <= '1;
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      for (int i = 0; i < PAGE_WORDS; i++)
        aux_mem[i] <= '1;
    end else if (seq_q == SEQ_PROG && addr_aux_q) begin
      aux_mem[idx_q[PAGE_IW-1:0]] <= pbuf[idx_q[PAGE_IW-1:0]];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q      <= '1;
      boot_fuse_q <= FUSE_NONE;
      ee_fuse_q   <= FUSE_NONE;
    end else if (seq_q == SEQ_POWERUP && timer_q == '0) begin
      lock_q      <= aux_mem[0][AUX_LOCK_MSB:AUX_LOCK_LSB];
      boot_fuse_q <= aux_mem[0][AUX_BOOT_MSB:AUX_BOOT_LSB];
      ee_fuse_q   <= aux_mem[0][AUX_EE_MSB:AUX_EE_LSB];
    end else if (cmd_issue && !addr_aux_q) begin
      if (cmd_code == CMD_LOCK)
        lock_q[tgt_row[ROW_W-1 -: REGION_W]] <= 1'b0;
      else if (cmd_code == CMD_UNLOCK)
        lock_q[tgt_row[ROW_W-1 -: REGION_W]] <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Page buffer and target location
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || buf_fill) begin
      for (int i = 0; i < PAGE_WORDS; i++)
        pbuf[i] <= '1;
    end else if (mem_take_wr) begin
      if (mem_size_i == SIZE_32)
        pbuf[widx] <= mem_wdata_i;
      else if (mem_addr_i[HALF_BIT])
        pbuf[widx][31:16] <= mem_wdata_i[31:16];
      else
        pbuf[widx][15:0] <= mem_wdata_i[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      loaded_q <= 1'b0;
    else if (mem_take_wr)
      loaded_q <= 1'b1;
    else if (buf_fill)
      loaded_q <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q     <= '0;
      addr_aux_q <= 1'b0;
    end else if (mem_take_wr) begin
      addr_q     <= mem_addr_i;
      addr_aux_q <= mem_aux_i;
    end else if (reg_wr_ok && wb_adr_i == REG_ADDR && wb_sel_i[0]) begin
      addr_q     <= wb_dat_i[ADDR_W-1:0];
      addr_aux_q <= wb_dat_i[ADDR_AUX_BIT];
    end
  end

  // ----------------------------------------------------------
  // Error flags: set wins over a write-one clear
  // ----------------------------------------------------------
  logic st_clr, if_clr;
  assign st_clr = wb_wr & (wb_adr_i == REG_STATUS) & wb_sel_i[0];
  assign if_clr = wb_wr & (wb_adr_i == REG_INTERRUPT_FLAG_REG) & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_err_q <= 1'b0;
      prog_err_q <= 1'b0;
      err_flag_q <= 1'b0;
    end else begin
      lock_err_q <= ev_lock_err |
                    (lock_err_q & ~(st_clr & wb_dat_i[ST_ERASE_PROTECT_ERROR_BIT]));
      prog_err_q <= ev_prog_err |
                    (prog_err_q & ~(st_clr & wb_dat_i[ST_PROGE_BIT]));
      err_flag_q <= ev_lock_err | ev_prog_err |
                    (err_flag_q & ~(if_clr & wb_dat_i[INTF_ERROR_BIT]));
    end
  end

  // ----------------------------------------------------------
  // Memory bus: reads with wait states, buffer writes
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mst_q       <= MS_IDLE;
      wcnt_q      <= 4'h0;
      mem_ack_o   <= 1'b0;
      mem_err_o   <= 1'b0;
      mem_rdata_o <= 32'h0000_0000;
    end else begin
      case (mst_q)
        MS_IDLE: begin
          mem_ack_o <= 1'b0;
          mem_err_o <= 1'b0;
          // No access taken while powering up or working
          if (mem_req_i && seq_idle) begin
            if (security_i && mem_ext_i) begin
              mem_err_o <= 1'b1;
              mst_q     <= MS_DONE;
            end else if (mem_we_i && mem_size_i == SIZE_8) begin
              mem_err_o <= 1'b1;
              mst_q     <= MS_DONE;
            end else if (mem_we_i) begin
              mem_ack_o <= 1'b1;
              mst_q     <= MS_DONE;
            end else if (rws_q == 4'h0) begin
              mem_rdata_o <= mem_aux_i ? aux_mem[widx] :
                             main_mem[mem_addr_i[ADDR_W-1:WORD_LSB]];
              mem_ack_o   <= 1'b1;
              mst_q       <= MS_DONE;
            end else begin
              wcnt_q <= rws_q - 4'h1;
              mst_q  <= MS_WAIT;
            end
          end
        end
        MS_WAIT: begin
          if (wcnt_q == 4'h0) begin
            mem_rdata_o <= mem_aux_i ? aux_mem[widx] :
                           main_mem[mem_addr_i[ADDR_W-1:WORD_LSB]];
            mem_ack_o   <= 1'b1;
            mst_q       <= MS_DONE;
          end else begin
            wcnt_q <= wcnt_q - 4'h1;
          end
        end
        MS_DONE: begin
          mem_ack_o <= 1'b0;
          mem_err_o <= 1'b0;
          mst_q     <= MS_IDLE;
        end
        default: mst_q <= MS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Sleep handling
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_lowpwr_o <= 1'b0;
      ready_prev_q   <= 1'b0;
      wake_o         <= 1'b0;
    end else begin
      flash_lowpwr_o <= sleep_i & (spr_q != SPR_OFF);
      ready_prev_q   <= ready_q;
      wake_o         <= sleep_i & ready_q & ~ready_prev_q;
    end
  end

endmodule

/* dv/fpc_flash_program_controller_monitor.sv */
`timescale 1ns/1ps
module fpc_flash_program_controller_monitor
  import fpc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        mem_req_i,
  input wire logic        mem_we_i,
  input wire logic        mem_ext_i,
  input wire logic [1:0]  mem_size_i,
  input wire logic        mem_ack_o,
  input wire logic        mem_err_o,
  input wire logic        guard_wp_i,
  input wire logic        sleep_i,
  input wire logic        security_i,
  input wire logic        ready_o,
  input wire logic        wake_o
);
  logic cmd_go;
  logic key_ok;
  logic quick;
  // Command write taken while idle, no memory traffic alongside
  assign cmd_go = wb_we_i && wb_ack_o && wb_adr_i == REG_CMD && ready_o
                  && !mem_req_i;
  assign key_ok = wb_dat_i[KEY_MSB:KEY_LSB] == CMD_KEY;
  assign quick = wb_dat_i[CMD_MSB:CMD_LSB] inside
                 {CMD_LOCK, CMD_UNLOCK, CMD_PBUF_CLR};
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_cmd_busy: assert property (
    cmd_go && key_ok && quick && !guard_wp_i |=> !ready_o [*2])
    else $error("ready stayed high after a command");
  a_bad_key: assert property (
    cmd_go && !key_ok |=> ready_o) else $error("bad key started work");
  a_guard_cmd: assert property (
    cmd_go && guard_wp_i |=> ready_o) else $error("guarded command ran");
  a_busy_stall: assert property (
    !ready_o && !$past(ready_o) && !$past(ready_o, 2) |-> !mem_ack_o)
    else $error("memory answered while busy");
  a_byte_err: assert property (
    $rose(mem_req_i) && mem_we_i && mem_size_i == SIZE_8 && ready_o
    |=> mem_err_o && !mem_ack_o) else $error("byte write not refused");
  a_secure_err: assert property (
    $rose(mem_req_i) && security_i && mem_ext_i && ready_o |=> mem_err_o)
    else $error("secured access not refused");
  a_pwrup_hold: assert property (
    $fell(rst_i) |-> (!ready_o && !mem_ack_o) [*8])
    else $error("access during power-up");
  a_wake_pulse: assert property (
    $rose(ready_o) && sleep_i |-> ##[0:1] wake_o) else $error("no wake");
  c_cmd: cover property (cmd_go && key_ok);
  c_err: cover property (mem_err_o);
  c_wake: cover property (wake_o);
endmodule

bind fpc_flash_program_controller
  fpc_flash_program_controller_monitor u_mon (
    .clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o,
    .mem_req_i, .mem_we_i, .mem_ext_i, .mem_size_i, .mem_ack_o,
    .mem_err_o, .guard_wp_i, .sleep_i, .security_i, .ready_o, .wake_o);

/* dv/fpc_mem_master.sv */
`timescale 1ns/1ps
module fpc_mem_master
  import fpc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              mem_ack_i,
  input  wire logic              mem_err_i,
  output logic                   mem_req_o,
  output logic                   mem_we_o,
  output logic                   mem_ext_o,
  output logic      [1:0]        mem_size_o,
  output logic      [ADDR_W-1:0] mem_addr_o,
  output logic      [31:0]       mem_wdata_o
);
  initial begin
    {mem_req_o, mem_we_o, mem_ext_o, mem_size_o} = '0;
    {mem_addr_o, mem_wdata_o} = '0;
  end
  // ----------------------------------------------------------
  // One transfer, held until answered or refused
  // ----------------------------------------------------------
  task automatic access(input logic we, ext, input logic [1:0] sz,
                        input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output int lat, output logic err);
    @(posedge clk_i);
    mem_req_o <= 1'b1;
    mem_we_o <= we;
    mem_ext_o <= ext;
    mem_size_o <= sz;
    mem_addr_o <= a;
    mem_wdata_o <= d;
    lat = 0;
    do begin
      @(posedge clk_i);
      lat++;
    end while (mem_ack_i !== 1'b1 && mem_err_i !== 1'b1 && lat < 4000);
    err = mem_err_i;
    // Released lines must not keep showing the last value
    mem_req_o <= 1'b0;
    mem_addr_o <= ~a;
    mem_wdata_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule

/* dv/tb_flash_program_controller.sv */
`timescale 1ns/1ps
module tb_flash_program_controller;
  import fpc_pkg::*;
  logic              clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1;
  logic              wb_cyc_i = 1'b0, wb_we_i = 1'b0, mem_aux_i = 1'b0;
  logic              guard_wp_i = 1'b0, sleep_i = 1'b0, security_i = 1'b0;
  logic [3:0]        wb_sel_i = 4'hf;
  logic [7:0]        wb_adr_i = 8'h00;
  logic [31:0]       wb_dat_i = 32'h0;
  logic              wb_stb_i, mem_req_i, mem_we_i, mem_ext_i, err;
  logic              wb_ack_o, mem_ack_o, mem_err_o, ready_o;
  logic              flash_lowpwr_o, wake_o;
  logic [1:0]        mem_size_i;
  logic [ADDR_W-1:0] mem_addr_i;
  logic [31:0]       mem_wdata_i, wb_dat_o, mem_rdata_o, cfgv;
  logic [31:0]       pg[16];
  logic [63:0]       e;
  logic [63:0]       exp_q[$];
  logic [3:0]        read_wait_cycles;
  int                fail_count = 0, check_count = 0, wake_cnt = 0, lat;
  assign wb_stb_i = wb_cyc_i;
  always #12.5 clk_i = ~clk_i;
  fpc_flash_program_controller dut (.*);
  fpc_mem_master u_mst (
    .clk_i, .mem_ack_i(mem_ack_o), .mem_err_i(mem_err_o),
    .mem_req_o(mem_req_i), .mem_we_o(mem_we_i), .mem_ext_o(mem_ext_i),
    .mem_size_o(mem_size_i), .mem_addr_o(mem_addr_i),
    .mem_wdata_o(mem_wdata_i));
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic bound(int n);
    if (n >= 4000) begin
      fail_count++;
      test_done;
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d,
                    logic [31:0] m = 32'h0);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    if (!w) exp_q.push_back({m, d});
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 4000);
    bound(n);
    wb_cyc_i <= 1'b0;
    wb_dat_i <= ~d;
  endtask
  task automatic xfer(logic w, logic [1:0] sz, logic [ADDR_W-1:0] a,
                      logic [31:0] d, logic [31:0] m = 32'h0);
    if (!w) exp_q.push_back({m, d});
    u_mst.access(w, 1'b0, sz, a, w ? d : 32'h0, lat, err);
    bound(lat);
  endtask
  task automatic cmd(logic [6:0] c);
    wb(1'b1, REG_CMD, {16'h0, CMD_KEY, 1'b0, c});
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    repeat (2) @(posedge clk_i);
    while (ready_o !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    bound(n);
  endtask
  // ----------------------------------------------------------
  // Result watcher: compares each read against the oldest note
  // ----------------------------------------------------------
  always @(posedge clk_i) begin
    if (wake_o === 1'b1) wake_cnt++;
    if ((wb_ack_o === 1'b1 && !wb_we_i) || (mem_ack_o === 1'b1 && !mem_we_i))
    begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : {32'hffffffff, 32'hx};
      check("read", (wb_ack_o === 1'b1 ? wb_dat_o : mem_rdata_o) & e[63:32],
            e[31:0] & e[63:32]);
    end
  end
  initial begin
    void'($urandom(32'hf993));
    read_wait_cycles = 4'($urandom_range(3, 0));
    cfgv = {24'h0, 1'b0, 2'h0, read_wait_cycles, 1'b0};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    xfer(1'b0, SIZE_32, 15'h0, 32'h0);
    check("ready", ready_o, 1'b1);
    wb(1'b0, REG_LOCK, 32'hffff, 32'hffff);
    wb(1'b0, REG_STATUS, 32'h0, 32'he);
    wb(1'b0, 8'h40, 32'h0, '1);
    wb(1'b1, REG_CMD, {16'h0, 8'h00, 1'b0, CMD_LOCK});
    wb(1'b0, REG_INTERRUPT_FLAG_REG, 32'h1, 32'h1);
    wb(1'b1, REG_CFG, cfgv);
    wb(1'b1, REG_ADDR, 32'h0);
    cmd(CMD_ERASE_ROW);
    wb(1'b0, REG_INTERRUPT_FLAG_REG, 32'h0, 32'h1);
    cmd(CMD_LOCK);
    xfer(1'b0, SIZE_32, 15'h0, 32'hffffffff, 32'hffffffff);
    check("ready", ready_o, 1'b1);
    wb(1'b0, REG_LOCK, 32'hffff, 32'hffff);
    for (int p = 0; p < 4; p++) begin
      xfer(1'b0, SIZE_32, ADDR_W'(p * 64 + 60), '1, '1);
      check("latency", lat, 2 + read_wait_cycles);
    end
    for (int i = 0; i < 16; i++) begin
      pg[i] = $urandom;
      xfer(1'b1, SIZE_32, ADDR_W'(i * 4), pg[i]);
      if (i == 14) wb(1'b0, REG_STATUS, 32'h2, 32'h2);
    end
    wait_rdy;
    wb(1'b0, REG_ADDR, 32'h3c, 32'h80007fff);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b0, SIZE_32, ADDR_W'(i * 4), pg[i], '1);
    end
    xfer(1'b0, SIZE_32, 15'h40, '1, '1);
    cfgv[CFG_MANUAL_WRITE_SEL_BIT] = 1'b1;
    wb(1'b1, REG_CFG, cfgv);
    xfer(1'b1, 2'h1, 15'h40, 32'h1234);
    cmd(CMD_WRITE_PAGE);
    wait_rdy;
    xfer(1'b0, SIZE_32, 15'h40, 32'hffff1234, '1);
    xfer(1'b1, SIZE_32, 15'h80, 32'h0);
    cmd(CMD_PBUF_CLR);
    wait_rdy;
    cmd(CMD_WRITE_PAGE);
    wait_rdy;
    xfer(1'b0, SIZE_32, 15'h80, '1, '1);
    u_mst.access(1'b1, 1'b0, SIZE_8, 15'h100, 32'h0, lat, err);
    check("byte_err", err, 1'b1);
    security_i <= 1'b1;
    u_mst.access(1'b0, 1'b1, SIZE_32, 15'h0, 32'h0, lat, err);
    check("secure_err", err, 1'b1);
    security_i <= 1'b0;
    wb(1'b1, REG_ADDR, 32'h0);
    cmd(CMD_LOCK);
    wait_rdy;
    wb(1'b0, REG_LOCK, 32'hfffe, 32'hffff);
    cmd(CMD_ERASE_ROW);
    wait_rdy;
    wb(1'b0, REG_STATUS, 32'h8, 32'h8);
    xfer(1'b0, SIZE_32, 15'h0, pg[0], '1);
    guard_wp_i <= 1'b1;
    wb(1'b1, REG_CFG, 32'h0);
    wb(1'b0, REG_CFG, cfgv, 32'h39e);
    cmd(CMD_UNLOCK);
    wb(1'b0, REG_LOCK, 32'hfffe, 32'hffff);
    wb(1'b1, REG_STATUS, 32'h8);
    wb(1'b0, REG_STATUS, 32'h0, 32'h8);
    guard_wp_i <= 1'b0;
    sleep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("lowpwr", flash_lowpwr_o, 1'b1);
    cmd(CMD_UNLOCK);
    wait_rdy;
    repeat (2) @(posedge clk_i);
    check("wake", wake_cnt, 1);
    wb(1'b0, REG_LOCK, 32'hffff, 32'hffff);
    sleep_i <= 1'b0;
    mem_aux_i <= 1'b1;
    xfer(1'b1, SIZE_32, 15'h0, 32'hffee7fff);
    cmd(CMD_WRITE_PAGE);
    wait_rdy;
    xfer(1'b0, SIZE_32, 15'h0, 32'hffee7fff, '1);
    mem_aux_i <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_rdy;
    wb(1'b0, REG_LOCK, 32'h7fff, 32'hffff);
    cmd(CMD_ERASE_ROW);
    wb(1'b0, REG_STATUS, 32'h8, 32'h8);
    wb(1'b1, REG_ADDR, 32'h7f00);
    cmd(CMD_ERASE_ROW);
    wb(1'b0, REG_INTERRUPT_FLAG_REG, 32'h0, 32'h1);
    test_done;
  end
endmodule
